// *** verilog/iccf_pkg.sv ***
/*
  Package for the network-side call clearing machine: message codes,
  cause values, state encodings and timer defaults.
  Assumes a single clock domain and a message link that is already
  decoded into one-cycle strobes with a message code.
*/
package iccf_pkg;

  // Message codes on the decoded D-channel strobe interface.
  typedef enum logic [3:0] {
    ICCF_MSG_NONE       = 4'h0,
    ICCF_MSG_SETUP      = 4'h1,
    ICCF_MSG_CALL_PROC  = 4'h2,
    ICCF_MSG_ALERTING   = 4'h3,
    ICCF_MSG_CONNECT    = 4'h4,
    ICCF_MSG_PROGRESS   = 4'h5,
    ICCF_MSG_DISCONNECT = 4'h6,
    ICCF_MSG_RELEASE    = 4'h7,
    ICCF_MSG_REL_COMP   = 4'h8
  } iccf_msg_type;

  // Cause values that this block generates or inspects.
  localparam logic [6:0] ICCF_CAUSE_NONE = 7'h00;
  localparam logic [6:0] ICCF_CAUSE_BUSY = 7'h11;
  localparam logic [6:0] ICCF_CAUSE_NO_CIRCUIT = 7'h22;
  localparam logic [6:0] ICCF_CAUSE_TIMER_RECOVERY = 7'h66;

  // Call states, one-hot.
  typedef enum logic [4:0] {
    ICCF_ST_NULL     = 5'h01,
    ICCF_ST_PROCEED  = 5'h02,
    ICCF_ST_ACTIVE   = 5'h04,
    ICCF_ST_DISC_IND = 5'h08,
    ICCF_ST_REL_REQ  = 5'h10
  } iccf_state_type;

  // In-band treatment selector.
  typedef enum logic [1:0] {
    ICCF_TONE_NONE     = 2'h0,
    ICCF_TONE_ANNOUNCE = 2'h1,
    ICCF_TONE_INTERCEPT = 2'h2
  } iccf_tone_type;

  // Timer defaults in protocol ticks, and the tick divider.
  localparam int ICCF_T305_TICKS = 30;
  localparam int ICCF_T308_TICKS = 4;
  localparam int ICCF_TICK_NS = 1000;
  localparam int ICCF_CLK_NS = 8;
  localparam int ICCF_TICK_CYCLES = ICCF_TICK_NS / ICCF_CLK_NS;
  localparam int ICCF_TMR_W = 16;

endpackage

// *** verilog/iccf_tick.sv ***
/*
  Protocol tick divider: one-cycle enable every DIV cycles.
  Assumes mclk and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module iccf_tick import iccf_pkg::*; #(
  parameter int DIV = ICCF_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic tick
);

  logic [15:0] cnt_ff; // Cycles left until the next tick.
  logic [15:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // Count down the divider and flag wrap.
  always_comb begin
    nxt_tick = (cnt_ff == 16'h0000);
    nxt_cnt = nxt_tick ? 16'(DIV - 1) : cnt_ff - 16'h0001;
  end

  // Register the counter.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule // iccf_tick

// *** verilog/iccf_timer.sv ***
/*
  One supervision timer counting protocol ticks. Start reloads, stop
  halts and keeps the count, expiry is a one-cycle pulse. Assumes tick is a one-cycle enable.
*/
`timescale 1ns/1ps
module iccf_timer import iccf_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [ICCF_TMR_W-1:0] len,
  output logic running,
  output logic expired
);

  logic [ICCF_TMR_W-1:0] cnt_ff; // Ticks left.
  logic [ICCF_TMR_W-1:0] nxt_cnt;
  logic run_ff;
  logic nxt_run;
  logic exp_ff;
  logic nxt_exp;

  // Start wins over stop so a restart in the same cycle is not lost.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_exp = 1'b0;
    if (start) begin
      nxt_cnt = len;
      nxt_run = 1'b1;
    end else if (stop) begin
      nxt_run = 1'b0;
    end else if (run_ff && tick) begin
      if (cnt_ff <= 16'h0001) begin
        nxt_run = 1'b0;
        nxt_exp = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
    end
  end

  // Register the timer.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      exp_ff <= nxt_exp;
    end
  end

  assign running = run_ff;
  assign expired = exp_ff;

endmodule // iccf_timer

// *** verilog/iccf_call.sv ***
/*
  Network-side per-call clearing state machine with in-band treatment
  decisions. Holds the call state, drives outgoing message strobes and
  bearer-channel controls, and runs two supervision timers.
  Assumes decoded incoming messages arrive as one-cycle strobes with a
  code and cause, and that the transmitter accepts one message a cycle.
*/
// Contract
// - Network clear: DISCONNECT, start T305, Disconnect Indication.
// - Plain clearing also disconnects the bearer channel.
// - RELEASE while clearing: stop T305, complete, Null.
// - T305 expiry: RELEASE cause 102, T308, Release Request.
// - DISCONNECT in Disconnect Indication: RELEASE, T308.
// - RELEASE in Release Request: complete, Null.
// - SETUP for busy channel gets RELEASE COMPLETE.
// - Valid SETUP: CALL PROCEEDING, cut through, route.
// - Congestion cause 34: network plays announcement.
// - Other congestion: PROGRESS, play tone.
`timescale 1ns/1ps
module iccf_call import iccf_pkg::*; #(
  parameter int T305_LEN = ICCF_T305_TICKS,
  parameter int T308_LEN = ICCF_T308_TICKS,
  parameter int TICK_DIV = ICCF_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire iccf_msg_type rx_msg,
  input wire logic [6:0] rx_cause,
  input wire logic chan_busy,
  input wire logic setup_ok,
  input wire logic clear_req,
  input wire logic tones_on,
  input wire logic congest,
  input wire logic [6:0] congest_cause,
  output logic tx_valid,
  output iccf_msg_type tx_msg,
  output logic [6:0] tx_cause,
  output logic bearer_conn,
  output logic bearer_free,
  output logic callref_free,
  output logic route_fwd,
  output iccf_tone_type tone,
  output iccf_state_type state
);

  ////////////////////////////////////////////////////////////////////////
  // Tick and timers.

  logic tick; // Protocol tick enable.
  logic t305_start;
  logic t305_stop;
  logic t305_run;
  logic t305_exp;
  logic t308_start;
  logic t308_stop;
  logic t308_run;
  logic t308_exp;

  iccf_tick #(.DIV(TICK_DIV)) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Both lengths are parameters so a bench can shorten them.
  iccf_timer u_t305 (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick),
    .start(t305_start),
    .stop(t305_stop),
    .len(ICCF_TMR_W'(T305_LEN)),
    .running(t305_run),
    .expired(t305_exp)
  );

  iccf_timer u_t308 (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick),
    .start(t308_start),
    .stop(t308_stop),
    .len(ICCF_TMR_W'(T308_LEN)),
    .running(t308_run),
    .expired(t308_exp)
  );

  ////////////////////////////////////////////////////////////////////////
  // Call state machine.

  iccf_state_type st_ff; // Current call state.
  iccf_state_type nxt_st;
  logic tx_valid_ff; // Outgoing message strobe.
  logic nxt_tx_valid;
  iccf_msg_type tx_msg_ff;
  iccf_msg_type nxt_tx_msg;
  logic [6:0] tx_cause_ff;
  logic [6:0] nxt_tx_cause;
  logic conn_ff; // Bearer channel part of the connection.
  logic nxt_conn;
  logic bfree_ff; // Bearer channel released, one-cycle pulse.
  logic nxt_bfree;
  logic cfree_ff; // Call reference released, one-cycle pulse.
  logic nxt_cfree;
  logic route_ff; // Route the call onward, one-cycle pulse.
  logic nxt_route;
  iccf_tone_type tone_ff;
  iccf_tone_type nxt_tone;

  // A received message is a one-cycle event; it takes priority over a
  // local request and timer expiry so the peer's view is answered first.
  always_comb begin
    nxt_st = st_ff;
    nxt_tx_valid = 1'b0;
    nxt_tx_msg = ICCF_MSG_NONE;
    nxt_tx_cause = ICCF_CAUSE_NONE;
    nxt_conn = conn_ff;
    nxt_bfree = 1'b0;
    nxt_cfree = 1'b0;
    nxt_route = 1'b0;
    nxt_tone = tone_ff;
    t305_start = 1'b0;
    t305_stop = 1'b0;
    t308_start = 1'b0;
    t308_stop = 1'b0;
    unique case (st_ff)
      ICCF_ST_NULL: begin
        if (rx_valid && rx_msg == ICCF_MSG_SETUP) begin
          if (chan_busy || !setup_ok) begin
            // Glare or failed validation: refuse; on glare the originator can pick another channel.
            nxt_tx_valid = 1'b1;
            nxt_tx_msg = ICCF_MSG_REL_COMP;
            nxt_cfree = 1'b1;
          end else begin
            nxt_tx_valid = 1'b1;
            nxt_tx_msg = ICCF_MSG_CALL_PROC;
            nxt_conn = 1'b1;
            nxt_route = 1'b1;
            nxt_st = ICCF_ST_PROCEED;
          end
        end
      end
      ICCF_ST_PROCEED, ICCF_ST_ACTIVE: begin
        if (rx_valid && rx_msg == ICCF_MSG_CONNECT) begin
          nxt_st = ICCF_ST_ACTIVE;
        end else if (congest && st_ff == ICCF_ST_PROCEED &&
                     tone_ff == ICCF_TONE_NONE) begin
          if (congest_cause == ICCF_CAUSE_NO_CIRCUIT) begin
            nxt_tone = ICCF_TONE_ANNOUNCE;
          end else begin
            // PROGRESS forces cut-through along the whole path.
            nxt_tx_valid = 1'b1;
            nxt_tx_msg = ICCF_MSG_PROGRESS;
            nxt_tx_cause = congest_cause;
            nxt_tone = ICCF_TONE_INTERCEPT;
          end
        end else if (clear_req) begin
          nxt_tx_valid = 1'b1;
          nxt_tx_msg = ICCF_MSG_DISCONNECT;
          t305_start = 1'b1;
          // Without tones the channel drops now; with tones it stays
          // connected so the peer still hears them.
          if (!tones_on) begin
            nxt_conn = 1'b0;
          end
          nxt_st = ICCF_ST_DISC_IND;
        end
      end
      ICCF_ST_DISC_IND: begin
        if (rx_valid && rx_msg == ICCF_MSG_RELEASE) begin
          t305_stop = 1'b1;
          nxt_conn = 1'b0;
          nxt_bfree = 1'b1;
          nxt_tx_valid = 1'b1;
          nxt_tx_msg = ICCF_MSG_REL_COMP;
          nxt_cfree = 1'b1;
          nxt_tone = ICCF_TONE_NONE;
          nxt_st = ICCF_ST_NULL;
        end else if (rx_valid && rx_msg == ICCF_MSG_DISCONNECT) begin
          t305_stop = 1'b1;
          nxt_conn = 1'b0;
          nxt_tx_valid = 1'b1;
          nxt_tx_msg = ICCF_MSG_RELEASE;
          t308_start = 1'b1;
          nxt_tone = ICCF_TONE_NONE;
          nxt_st = ICCF_ST_REL_REQ;
        end else if (t305_exp) begin
          nxt_tx_valid = 1'b1;
          nxt_tx_msg = ICCF_MSG_RELEASE;
          nxt_tx_cause = ICCF_CAUSE_TIMER_RECOVERY;
          t308_start = 1'b1;
          nxt_conn = 1'b0;
          nxt_tone = ICCF_TONE_NONE;
          nxt_st = ICCF_ST_REL_REQ;
        end
      end
      ICCF_ST_REL_REQ: begin
        if (rx_valid && (rx_msg == ICCF_MSG_RELEASE ||
                         rx_msg == ICCF_MSG_REL_COMP)) begin
          t308_stop = 1'b1;
          nxt_bfree = 1'b1;
          nxt_cfree = 1'b1;
          // Collision answers RELEASE; a plain completion needs none.
          nxt_tx_valid = (rx_msg == ICCF_MSG_RELEASE);
          nxt_tx_msg = (rx_msg == ICCF_MSG_RELEASE) ?
                       ICCF_MSG_REL_COMP : ICCF_MSG_NONE;
          nxt_st = ICCF_ST_NULL;
        end else if (t308_exp) begin
          // Peer silent: give up locally; restart handles maintenance.
          nxt_bfree = 1'b1;
          nxt_cfree = 1'b1;
          nxt_tx_valid = 1'b1;
          nxt_tx_msg = ICCF_MSG_REL_COMP;
          nxt_st = ICCF_ST_NULL;
        end
      end
      default: begin
        nxt_st = ICCF_ST_NULL;
        nxt_conn = 1'b0;
        nxt_tone = ICCF_TONE_NONE;
      end
    endcase
  end

  // Register the call state and every output.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= ICCF_ST_NULL;
      tx_valid_ff <= 1'b0;
      tx_msg_ff <= ICCF_MSG_NONE;
      tx_cause_ff <= ICCF_CAUSE_NONE;
      conn_ff <= 1'b0;
      bfree_ff <= 1'b0;
      cfree_ff <= 1'b0;
      route_ff <= 1'b0;
      tone_ff <= ICCF_TONE_NONE;
    end else begin
      st_ff <= nxt_st;
      tx_valid_ff <= nxt_tx_valid;
      tx_msg_ff <= nxt_tx_msg;
      tx_cause_ff <= nxt_tx_cause;
      conn_ff <= nxt_conn;
      bfree_ff <= nxt_bfree;
      cfree_ff <= nxt_cfree;
      route_ff <= nxt_route;
      tone_ff <= nxt_tone;
    end
  end

  assign tx_valid = tx_valid_ff;
  assign tx_msg = tx_msg_ff;
  assign tx_cause = tx_cause_ff;
  assign bearer_conn = conn_ff;
  assign bearer_free = bfree_ff;
  assign callref_free = cfree_ff;
  assign route_fwd = route_ff;
  assign tone = tone_ff;
  assign state = st_ff;

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_clear_start;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_ACTIVE && clear_req && !rx_valid)
      |=> (tx_msg_ff == ICCF_MSG_DISCONNECT && st_ff == ICCF_ST_DISC_IND
           && t305_run);
  endproperty
  a_clear_start: assert property (p_clear_start)
    else $error("Clear did not send disconnect and run T305.");

  property p_plain_drop;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_ACTIVE && clear_req && !rx_valid && !tones_on)
      |=> !conn_ff;
  endproperty
  a_plain_drop: assert property (p_plain_drop)
    else $error("Bearer kept on plain clearing.");

  property p_rel_in_disc;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_DISC_IND && rx_valid && rx_msg == ICCF_MSG_RELEASE)
      |=> (tx_msg_ff == ICCF_MSG_REL_COMP && cfree_ff &&
           st_ff == ICCF_ST_NULL ##1 !t305_run);
  endproperty
  a_rel_in_disc: assert property (p_rel_in_disc)
    else $error("Release in disconnect indication mishandled.");

  property p_t305_exp;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_DISC_IND && t305_exp && !rx_valid)
      |=> (tx_msg_ff == ICCF_MSG_RELEASE &&
           tx_cause_ff == ICCF_CAUSE_TIMER_RECOVERY && t308_run);
  endproperty
  a_t305_exp: assert property (p_t305_exp)
    else $error("T305 expiry did not send release with cause.");

  property p_collide;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_DISC_IND && rx_valid &&
     rx_msg == ICCF_MSG_DISCONNECT)
      |=> (tx_msg_ff == ICCF_MSG_RELEASE && !conn_ff &&
           st_ff == ICCF_ST_REL_REQ);
  endproperty
  a_collide: assert property (p_collide)
    else $error("Disconnect collision mishandled.");

  property p_rel_coll;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_REL_REQ && rx_valid && rx_msg == ICCF_MSG_RELEASE)
      |=> (tx_msg_ff == ICCF_MSG_REL_COMP && st_ff == ICCF_ST_NULL);
  endproperty
  a_rel_coll: assert property (p_rel_coll)
    else $error("Release collision not completed.");

  property p_busy;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_NULL && rx_valid && rx_msg == ICCF_MSG_SETUP &&
     chan_busy) |=> (tx_msg_ff == ICCF_MSG_REL_COMP &&
                     st_ff == ICCF_ST_NULL);
  endproperty
  a_busy: assert property (p_busy)
    else $error("Busy channel setup not refused.");

  property p_setup;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_NULL && rx_valid && rx_msg == ICCF_MSG_SETUP &&
     !chan_busy && setup_ok)
      |=> (tx_msg_ff == ICCF_MSG_CALL_PROC && conn_ff && route_ff);
  endproperty
  a_setup: assert property (p_setup)
    else $error("Valid setup not proceeded.");

  property p_announce;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_PROCEED && !rx_valid && congest &&
     congest_cause == ICCF_CAUSE_NO_CIRCUIT && tone_ff == ICCF_TONE_NONE)
      |=> (tone_ff == ICCF_TONE_ANNOUNCE && !tx_valid_ff);
  endproperty
  a_announce: assert property (p_announce)
    else $error("No-circuit congestion gave no announcement.");

  property p_intercept;
    @(posedge mclk) disable iff (!rst_n)
    (st_ff == ICCF_ST_PROCEED && !rx_valid && congest &&
     congest_cause != ICCF_CAUSE_NO_CIRCUIT && tone_ff == ICCF_TONE_NONE)
      |=> (tx_msg_ff == ICCF_MSG_PROGRESS && tone_ff == ICCF_TONE_INTERCEPT);
  endproperty
  a_intercept: assert property (p_intercept)
    else $error("Congestion gave no progress and tone.");

  c_norm: cover property (@(posedge mclk) disable iff (!rst_n)
    st_ff == ICCF_ST_DISC_IND ##[1:200] st_ff == ICCF_ST_NULL);
  c_t305: cover property (@(posedge mclk) disable iff (!rst_n)
    t305_exp && st_ff == ICCF_ST_DISC_IND);
  c_coll: cover property (@(posedge mclk) disable iff (!rst_n)
    st_ff == ICCF_ST_REL_REQ && rx_valid && rx_msg == ICCF_MSG_RELEASE);

endmodule // iccf_call

// *** sim/iccf_peer.sv ***
/*
  Behavioural user-side peer for the clearing machine.
  Assumes it sees the block's outgoing strobes and that the bench
  injects its own messages through the command port.
*/
`timescale 1ns/1ps
module iccf_peer import iccf_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire iccf_msg_type tx_msg,
  input wire logic auto_en,
  input wire logic cmd_valid,
  input wire iccf_msg_type cmd_msg,
  output logic rx_valid,
  output iccf_msg_type rx_msg,
  output logic [6:0] rx_cause,
  output logic maint
);
  ////////////////////////////////////////////////////////////////////
  logic aut_vld_ff; // Automatic answer pending.
  iccf_msg_type aut_msg_ff; // Automatic answer code.
  logic rel_req_ff; // Peer sits in Release Request.
  logic retry_ff; // First T308 expiry already seen.
  logic [3:0] tmr_ff; // Peer T308 count in cycles.
  logic [3:0] pat_ff; // Junk pattern for an idle link.
  // One process keeps the peer simple; it is only a model.
  always_ff @(posedge mclk) begin
    pat_ff <= pat_ff + 4'h5;
    aut_vld_ff <= 1'b0;
    if (!rst_n) begin
      pat_ff <= 4'h0;
      rel_req_ff <= 1'b0;
      retry_ff <= 1'b0;
      maint <= 1'b0;
      tmr_ff <= 4'h0;
    end else if (tx_valid && auto_en) begin
      if (tx_msg == ICCF_MSG_DISCONNECT) begin
        aut_vld_ff <= 1'b1;
        aut_msg_ff <= ICCF_MSG_RELEASE;
        rel_req_ff <= 1'b1;
        retry_ff <= 1'b0;
        tmr_ff <= 4'hc;
      end else if (tx_msg == ICCF_MSG_RELEASE && rel_req_ff) begin
        aut_vld_ff <= 1'b1;
        aut_msg_ff <= ICCF_MSG_REL_COMP;
        rel_req_ff <= 1'b0;
      end else if (tx_msg == ICCF_MSG_REL_COMP) begin
        rel_req_ff <= 1'b0;
      end
    end else if (rel_req_ff && auto_en) begin
      if (tmr_ff != 4'h0) begin
        tmr_ff <= tmr_ff - 4'h1;
      end else if (!retry_ff) begin
        aut_vld_ff <= 1'b1;
        aut_msg_ff <= ICCF_MSG_RELEASE;
        retry_ff <= 1'b1;
        tmr_ff <= 4'hc;
      end else begin
        maint <= 1'b1;
        rel_req_ff <= 1'b0;
      end
    end
  end
  // An idle link shows a changing pattern that steps through every 4-bit code.
  assign rx_valid = cmd_valid | aut_vld_ff;
  assign rx_msg = cmd_valid ? cmd_msg :
                  aut_vld_ff ? aut_msg_ff : iccf_msg_type'(pat_ff);
  // A peer DISCONNECT reports a busy far end.
  assign rx_cause = (cmd_valid && cmd_msg == ICCF_MSG_DISCONNECT) ?
                    ICCF_CAUSE_BUSY : {3'h5, pat_ff};
endmodule // iccf_peer

// *** sim/iccf_call_tb.sv ***
/*
  Self-checking bench for the network-side clearing machine.
  Assumes the peer model in iccf_peer and short timer parameters.
*/
`timescale 1ns/1ps
module iccf_call_tb import iccf_pkg::*;;
  ////////////////////////////////////////////////////////////////////
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_valid, chan_busy = 1'b0, clear_req = 1'b0, tones_on = 1'b0;
  logic congest = 1'b0, cmd_valid = 1'b0, auto_en = 1'b0, maint;
  logic [6:0] rx_cause, tx_cause;
  logic [6:0] congest_cause = 7'h00;
  iccf_msg_type rx_msg, tx_msg;
  iccf_msg_type cmd_msg = ICCF_MSG_NONE;
  logic tx_valid, bearer_conn, bearer_free, callref_free, route_fwd;
  iccf_tone_type tone;
  iccf_state_type state;
  int err_total = 0;
  logic setup_ok = 1'b1;
  int cmp_count = 0;
  // One scripted step: message or clear in, outputs expected.
  typedef struct {
    iccf_msg_type m; logic busy; logic clr;
    iccf_msg_type ex; iccf_state_type es; logic eb;
  } iccf_row_type;
  iccf_row_type rows [6];
  always #4 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////
  iccf_call #(.T305_LEN(2), .T308_LEN(2), .TICK_DIV(2)) iccf_call_i (
    .mclk(mclk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_msg(rx_msg),
    .rx_cause(rx_cause), .chan_busy(chan_busy), .setup_ok(setup_ok),
    .clear_req(clear_req), .tones_on(tones_on), .congest(congest),
    .congest_cause(congest_cause), .tx_valid(tx_valid),
    .tx_msg(tx_msg), .tx_cause(tx_cause), .bearer_conn(bearer_conn),
    .bearer_free(bearer_free), .callref_free(callref_free),
    .route_fwd(route_fwd), .tone(tone), .state(state));
  iccf_peer iccf_peer_i (
    .mclk(mclk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_msg(tx_msg),
    .auto_en(auto_en), .cmd_valid(cmd_valid), .cmd_msg(cmd_msg),
    .rx_valid(rx_valid), .rx_msg(rx_msg), .rx_cause(rx_cause),
    .maint(maint));
  ////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compares one value of up to eight bits.
  task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Drives one step a cycle after the last, one cycle wide.
  task automatic send(input iccf_msg_type m, input logic clr);
    @(posedge mclk);
    #1;
    cmd_valid = (m != ICCF_MSG_NONE);
    cmd_msg = m;
    clear_req = clr;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    clear_req = 1'b0;
  endtask
  // Waits for the next outgoing strobe and checks its code.
  task automatic wait_tx(input iccf_msg_type e);
    int i;
    for (i = 0; i < 60 && tx_valid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 60) begin
      err_total++;
      test_done();
    end
    chk_v(8'(tx_msg), 8'(e));
  endtask
  // Waits for the expected in-band treatment.
  task automatic wait_tone(input iccf_tone_type e);
    int i;
    for (i = 0; i < 60 && tone !== e; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 60) begin
      err_total++;
      test_done();
    end
    chk_v(8'(tone), 8'(e));
  endtask
  // Resets for n cycles and checks the idle outputs.
  task automatic do_reset(input int n);
    @(posedge mclk);
    #1;
    rst_n = 1'b0;
    repeat (n) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chk_v(8'(state), 8'(ICCF_ST_NULL));
    chk_v({6'h0, tx_valid, bearer_conn}, 8'h00);
    chk_v(8'(tone), 8'(ICCF_TONE_NONE));
  endtask
  // Brings a call up to the Active state.
  task automatic go_active();
    send(ICCF_MSG_SETUP, 1'b0);
    chk_v({7'h0, route_fwd}, 8'h01);
    send(ICCF_MSG_CONNECT, 1'b0);
    chk_v(8'(state), 8'(ICCF_ST_ACTIVE));
    chk_v(8'(tone), 8'(ICCF_TONE_NONE));
  endtask
  ////////////////////////////////////////////////////////////////////
  // Main sequence: table first, then the awkward cases.
  initial begin
    rows[0] = '{ICCF_MSG_REL_COMP, 1'b0, 1'b0, ICCF_MSG_NONE,
                ICCF_ST_NULL, 1'b0};
    rows[1] = '{ICCF_MSG_SETUP, 1'b1, 1'b0, ICCF_MSG_REL_COMP,
                ICCF_ST_NULL, 1'b0};
    rows[2] = '{ICCF_MSG_SETUP, 1'b0, 1'b0, ICCF_MSG_CALL_PROC,
                ICCF_ST_PROCEED, 1'b1};
    rows[3] = '{ICCF_MSG_CONNECT, 1'b0, 1'b0, ICCF_MSG_NONE,
                ICCF_ST_ACTIVE, 1'b1};
    rows[4] = '{ICCF_MSG_NONE, 1'b0, 1'b1, ICCF_MSG_DISCONNECT,
                ICCF_ST_DISC_IND, 1'b0};
    rows[5] = '{ICCF_MSG_RELEASE, 1'b0, 1'b0, ICCF_MSG_REL_COMP,
                ICCF_ST_NULL, 1'b0};
    do_reset(20);
    foreach (rows[k]) begin
      chan_busy = rows[k].busy;
      send(rows[k].m, rows[k].clr);
      chk_v({7'h0, tx_valid}, {7'h0, rows[k].ex != ICCF_MSG_NONE});
      chk_v(8'(tx_msg), 8'(rows[k].ex));
      chk_v(8'(state), 8'(rows[k].es));
      chk_v({7'h0, bearer_conn}, {7'h0, rows[k].eb});
    end
    chan_busy = 1'b0;
    // Clearing with tones kept, no answer: T305 runs out.
    go_active();
    tones_on = 1'b1;
    send(ICCF_MSG_NONE, 1'b1);
    chk_v(8'(tx_msg), 8'(ICCF_MSG_DISCONNECT));
    chk_v({7'h0, bearer_conn}, 8'h01);
    tones_on = 1'b0;
    @(posedge mclk);
    #1;
    wait_tx(ICCF_MSG_RELEASE);
    chk_v({1'b0, tx_cause}, {1'b0, ICCF_CAUSE_TIMER_RECOVERY});
    chk_v(8'(state), 8'(ICCF_ST_REL_REQ));
    send(ICCF_MSG_RELEASE, 1'b0);
    chk_v(8'(tx_msg), 8'(ICCF_MSG_REL_COMP));
    chk_v(8'(state), 8'(ICCF_ST_NULL));
    // Clear collision, then T308 runs out in Release Request.
    // Tones keep the channel up, so the collision must drop it.
    go_active();
    tones_on = 1'b1;
    send(ICCF_MSG_NONE, 1'b1);
    tones_on = 1'b0;
    send(ICCF_MSG_DISCONNECT, 1'b0);
    chk_v(8'(tx_msg), 8'(ICCF_MSG_RELEASE));
    chk_v(8'(state), 8'(ICCF_ST_REL_REQ));
    chk_v({7'h0, bearer_conn}, 8'h00);
    @(posedge mclk);
    #1;
    wait_tx(ICCF_MSG_REL_COMP);
    chk_v(8'(state), 8'(ICCF_ST_NULL));
    // Full clear against the answering peer.
    auto_en = 1'b1;
    go_active();
    send(ICCF_MSG_NONE, 1'b1);
    @(posedge mclk);
    #1;
    wait_tx(ICCF_MSG_REL_COMP);
    chk_v({6'h0, bearer_free, callref_free}, 8'h03);
    chk_v(8'(state), 8'(ICCF_ST_NULL));
    auto_en = 1'b0;
    // Congestion with the no-circuit cause: announcement.
    send(ICCF_MSG_SETUP, 1'b0);
    congest_cause = ICCF_CAUSE_NO_CIRCUIT;
    congest = 1'b1;
    wait_tone(ICCF_TONE_ANNOUNCE);
    congest = 1'b0;
    do_reset(2);
    // Any other cause: progress message and intercept tone.
    send(ICCF_MSG_SETUP, 1'b0);
    congest_cause = 7'h2a;
    congest = 1'b1;
    // Let the proceeding strobe of the setup pass first.
    @(posedge mclk);
    #1;
    wait_tx(ICCF_MSG_PROGRESS);
    wait_tone(ICCF_TONE_INTERCEPT);
    congest = 1'b0;
    do_reset(2);
    // A setup that fails validation is refused as well.
    setup_ok = 1'b0;
    send(ICCF_MSG_SETUP, 1'b0);
    chk_v(8'(tx_msg), 8'(ICCF_MSG_REL_COMP));
    chk_v(8'(state), 8'(ICCF_ST_NULL));
    setup_ok = 1'b1;
    test_done();
  end
endmodule // iccf_call_tb
